// ==== lfps_exit_handshake_warm_reset.v ====
// lfps exit handshake and warm reset controller for the local port
//
// Contract
// [R01] device: ping versus u1 exit at 300 ns
// [R02] initiator sends lfps until success or failure
// [R03] responder validates 0.3 us, then answers lfps
// [R04] initiator succeeds within 2 ms or 10 ms
// [R05] t12: 300 ns validated plus 600 ns more; code counts the 600 ns from first sight of partner lfps
// [R06] concurrent u1 exit: send 900 ns total
// [R07] training ready, no gap beyond 20 ns
// [R08] responder succeeds after minimum t13-t11
// [R09] failure whenever success conditions are unmet
// [R10] short u1 limits unless timer or immediate
// [R11] responder max 1.2 us, then superspeed
// [R12] device: non-ping lfps always runs handshake
// [R13] device: warm reset path through recovery
// [R14] only downstream issues warm reset, not disabled
// [R15] device: warm reset told by burst length
// [R16] device: holds reset until lfps stops
// [R17] device: detect warm reset in 18-50 ms
// [R18] warm reset is one 80-120 ms burst
// [R19] device: recognise u1 exit at 300 ns
// [R20] device: local clock counters, one-cycle pulses
`include "lfps_hs_regs.vh"
`default_nettype none

module lfps_exit_handshake_warm_reset #(
  // no-response and relaxed limits, 2 ms
  parameter [`CNT_W-1:0] C_REL      = `MS2CYC(`T_REL_MS),
  // u3 wakeup limits, 10 ms
  parameter [`CNT_W-1:0] C_U3       = `MS2CYC(`T_U3_MS),
  // long minimum burst for u2, loopback and u3, 80 us
  parameter [`CNT_W-1:0] C_LONG_MIN = `US2CYC(`T_LONG_MIN_US),
  // warm reset burst length, 100 ms typical
  parameter [`CNT_W-1:0] C_WARM     = `MS2CYC(`T_WARM_MS)
) (
  input  wire       clk_sys_in,        // local port clock
  input  wire       rst_b_in,          // synchronous reset, low
  input  wire       clk_en_in,         // freezes all state when low
  input  wire       lfps_rx_in,        // lfps detector, high in burst
  input  wire       start_exit_in,     // begin exit as initiator
  input  wire       resp_arm_in,       // port in low power, may answer
  input  wire [1:0] exit_kind_in,      // u1, u2, loopback or u3
  input  wire       u2_timer_en_in,    // u2 inactivity timer enabled
  input  wire       immediate_exit_in, // exit right on u1 entry
  input  wire       ss_ready_in,       // training sequences ready
  input  wire       warm_reset_req_in, // issue warm reset
  input  wire       link_disabled_in,  // link in ss.disabled
  output wire       lfps_tx_out,       // lfps transmitter enable
  output wire       ss_tx_start_out,   // start superspeed signalling
  output wire       hs_success_out,    // handshake success pulse
  output wire       hs_fail_out,       // handshake failure pulse
  output wire       warm_active_out,   // warm reset burst in progress
  output wire       warm_done_out,     // warm reset burst ended pulse
  output wire       busy_out           // any sequence running
);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam [`CNT_W-1:0] C_VALID   = `NS2CYC_UP(`T_VALID_NS);
  localparam [`CNT_W-1:0] C_TAIL    = `NS2CYC_UP(`T_TAIL_NS);
  localparam [`CNT_W-1:0] C_U1_TOT  = `NS2CYC_UP(`T_U1_TOT_NS);
  localparam [`CNT_W-1:0] C_U1_RESP = `NS2CYC_UP(`T_U1_RESP_NS);
  localparam [`CNT_W-1:0] C_U1_RMAX = `NS2CYC_DN(`T_U1_RMAX_NS);
  localparam [`CNT_W-1:0] C_U1_SMAX = `NS2CYC_DN(`T_U1_SMAX_NS);
  localparam [`CNT_W-1:0] C_ONE     = `CNT_W'h00_0001;
  localparam [`CNT_W-1:0] C_ZERO    = `CNT_W'h00_0000;

  // one-hot states
  localparam [4:0] S_IDLE = `ST_IDLE;
  localparam [4:0] S_INIT = `ST_INIT;
  localparam [4:0] S_RESP = `ST_RESP;
  localparam [4:0] S_WARM = `ST_WARM;

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  reg  [4:0]        state_reg;    // current state
  reg  [1:0]        kind_reg;     // kind of the running handshake
  reg               relax_reg;    // relaxed limits latched at start
  reg  [`CNT_W-1:0] cnt_t_reg;    // own lfps time
  reg  [`CNT_W-1:0] cnt_p_reg;    // time since partner lfps seen
  reg  [`CNT_W-1:0] run_reg;      // length of current rx burst
  reg               seen_reg;     // partner lfps seen
  reg               vld_reg;      // partner lfps validated
  reg               tx_reg;       // lfps transmitter
  reg               succ_reg;     // success pulse
  reg               fail_reg;     // failure pulse
  reg               ss_go_reg;    // superspeed start pulse
  reg               wdone_reg;    // warm reset end pulse
  reg               rx_s1_reg;    // rx synchroniser, first stage
  reg               rx_s2_reg;    // rx synchroniser, second stage
  reg               rx_s3_reg;    // rx synchroniser, third stage
  reg               rx_lvl_reg;   // accepted rx level

  // ----------------------------------------------------------------
  // derived limits
  // ----------------------------------------------------------------
  wire is_u1   = (kind_reg == `KIND_U1);
  wire is_lpbk = (kind_reg == `KIND_LPBK);
  wire is_u3   = (kind_reg == `KIND_U3);

  // no-response timeout after t10
  wire [`CNT_W-1:0] to_max = is_u3 ? C_U3 : C_REL; // R04

  // least own lfps before leaving, counted from t10
  wire [`CNT_W-1:0] init_min = is_u1 ? C_U1_TOT : C_LONG_MIN; // R06

  // longest t12-t11, short only for plain u1
  wire [`CNT_W-1:0] tail_max = (is_u1 && !relax_reg) ? C_U1_SMAX :
                               (is_u3 ? C_U3 : C_REL); // R10

  // least t13-t11 for the responder
  wire [`CNT_W-1:0] resp_min = is_u1 ? C_U1_RESP : C_LONG_MIN; // R08

  // longest t13-t11 for the responder
  wire [`CNT_W-1:0] resp_max = is_u1 ?
                               (relax_reg ? C_REL : C_U1_RMAX) :
                               (is_u3 ? C_U3 : C_REL); // R11

  // loopback exit needs no training sequences
  wire ready_ok = is_lpbk | ss_ready_in; // R07

  // partner burst has lasted long enough to be valid
  wire rx_valid = (run_reg >= C_VALID); // R03

  // initiator success test at t12
  wire init_ok = vld_reg && (cnt_p_reg >= C_TAIL) &&
                 (cnt_t_reg >= init_min) && ready_ok; // R05

  // initiator failure test
  wire init_bad = (cnt_t_reg >= to_max) ||
                  (seen_reg && (cnt_p_reg >= tail_max)); // R09

  // ----------------------------------------------------------------
  // rx pin synchroniser and filter
  // ----------------------------------------------------------------
  // three stages; a change is taken once stages two and three agree
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      rx_s1_reg  <= 1'b0;
      rx_s2_reg  <= 1'b0;
      rx_s3_reg  <= 1'b0;
      rx_lvl_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      rx_s1_reg <= lfps_rx_in;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      // accept only a settled level
      if (rx_s2_reg == rx_s3_reg)
      begin
        rx_lvl_reg <= rx_s3_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // rx burst length counter
  // ----------------------------------------------------------------
  // counts cycles of the current burst, saturating at the valid mark
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      run_reg <= C_ZERO;
    end
    else if (clk_en_in)
    begin
      if (!rx_lvl_reg)
      begin
        // idle restarts the measurement
        run_reg <= C_ZERO;
      end
      else if (!rx_valid)
      begin
        run_reg <= run_reg + C_ONE; // R20
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake and warm reset state machine
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= S_IDLE;
      kind_reg  <= `KIND_U1;
      relax_reg <= 1'b0;
      cnt_t_reg <= C_ZERO;
      cnt_p_reg <= C_ZERO;
      seen_reg  <= 1'b0;
      vld_reg   <= 1'b0;
      tx_reg    <= 1'b0;
      succ_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      ss_go_reg <= 1'b0;
      wdone_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // pulses last one cycle
      succ_reg  <= 1'b0; // R20
      fail_reg  <= 1'b0;
      ss_go_reg <= 1'b0;
      wdone_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          cnt_t_reg <= C_ZERO;
          cnt_p_reg <= C_ZERO;
          seen_reg  <= 1'b0;
          vld_reg   <= 1'b0;
          if (warm_reset_req_in && !link_disabled_in)
          begin
            // warm reset taken from idle only, not while disabled
            state_reg <= S_WARM; // R14
            tx_reg    <= 1'b1;
          end
          else if (start_exit_in)
          begin
            // t10: initiator starts its lfps
            state_reg <= S_INIT; // R02
            kind_reg  <= exit_kind_in;
            relax_reg <= u2_timer_en_in | immediate_exit_in; // R10
            tx_reg    <= 1'b1;
          end
          else if (resp_arm_in && rx_valid)
          begin
            // t11: partner lfps validated, answer it
            state_reg <= S_RESP; // R03
            kind_reg  <= exit_kind_in;
            relax_reg <= u2_timer_en_in | immediate_exit_in;
            tx_reg    <= 1'b1;
          end
        end
        S_INIT:
        begin
          cnt_t_reg <= cnt_t_reg + C_ONE;
          // partner time counts from first sight of its lfps
          if (rx_lvl_reg && !seen_reg)
          begin
            seen_reg  <= 1'b1; // R05
            cnt_p_reg <= C_ZERO;
          end
          else if (seen_reg)
          begin
            cnt_p_reg <= cnt_p_reg + C_ONE;
          end
          // remember a validated partner burst
          if (seen_reg && rx_valid)
          begin
            vld_reg <= 1'b1;
          end
          if (init_ok)
          begin
            // stop lfps and start superspeed in the same cycle
            state_reg <= S_IDLE;
            tx_reg    <= 1'b0;
            succ_reg  <= 1'b1; // R04
            ss_go_reg <= !is_lpbk; // R07
          end
          else if (init_bad)
          begin
            state_reg <= S_IDLE;
            tx_reg    <= 1'b0;
            fail_reg  <= 1'b1; // R09
          end
        end
        S_RESP:
        begin
          cnt_t_reg <= cnt_t_reg + C_ONE;
          if ((cnt_t_reg >= resp_min) && ready_ok)
          begin
            // t13: minimum sent, switch to superspeed
            state_reg <= S_IDLE;
            tx_reg    <= 1'b0;
            succ_reg  <= 1'b1; // R08
            ss_go_reg <= !is_lpbk; // R11
          end
          else if (cnt_t_reg >= resp_max)
          begin
            state_reg <= S_IDLE;
            tx_reg    <= 1'b0;
            fail_reg  <= 1'b1; // R09
          end
        end
        S_WARM:
        begin
          cnt_t_reg <= cnt_t_reg + C_ONE;
          // one single burst of the full length
          if (cnt_t_reg >= (C_WARM - C_ONE))
          begin
            state_reg <= S_IDLE; // R18
            tx_reg    <= 1'b0;
            wdone_reg <= 1'b1;
          end
        end
        default:
        begin
          // illegal code, recover quietly
          state_reg <= S_IDLE;
          tx_reg    <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lfps_tx_out     = tx_reg;
  assign ss_tx_start_out = ss_go_reg;
  assign hs_success_out  = succ_reg;
  assign hs_fail_out     = fail_reg;
  assign warm_active_out = state_reg[`ST_WARM_BIT];
  assign warm_done_out   = wdone_reg;
  assign busy_out        = !state_reg[`ST_IDLE_BIT];

endmodule

`default_nettype wire

// ==== lfps_exit_handshake_warm_reset_tb.sv ====
// self-checking bench for the lfps handshake controller
`include "lfps_hs_regs.vh"
`default_nettype none
module lfps_exit_handshake_warm_reset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [23:0] C_WARM = 24'h0190; // shortened warm burst
  logic clk = 1'b0;   // local clock
  logic rst_b = 1'b0; // reset, low
  logic st = 1'b0, arm = 1'b0, rdy = 1'b1, wreq = 1'b0, dis = 1'b0;
  logic ans = 1'b1, go = 1'b0;  // partner controls
  logic en = 1'b1, u2t = 1'b0, imm = 1'b0; // enable and relaxed limits
  logic [1:0]  kd = 2'h0;       // handshake kind
  logic [15:0] dly = 16'h0000;  // partner answer delay
  logic [15:0] len = 16'h0000;  // partner burst length
  wire tx, rx, ss, ok, ko, wa, wd, bz, wdet;
  int bad_count = 0, n_compared = 0, cyc = 0, txn = 0;
  always #4 clk = ~clk;
  // cycle ceiling and length of the current lfps run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    txn <= tx ? txn + 1 : 0;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  lfps_exit_handshake_warm_reset #(.C_REL(24'h0258), .C_U3(24'h03e8),
    .C_LONG_MIN(24'h00c8), .C_WARM(C_WARM)) i_dut (
    .clk_sys_in(clk), .rst_b_in(rst_b), .clk_en_in(en), .lfps_rx_in(rx),
    .start_exit_in(st), .resp_arm_in(arm), .exit_kind_in(kd),
    .u2_timer_en_in(u2t), .immediate_exit_in(imm), .ss_ready_in(rdy),
    .warm_reset_req_in(wreq), .link_disabled_in(dis), .lfps_tx_out(tx),
    .ss_tx_start_out(ss), .hs_success_out(ok), .hs_fail_out(ko),
    .warm_active_out(wa), .warm_done_out(wd), .busy_out(bz));
  lfps_usp_model i_usp (.clk_in(clk), .tx_in(tx), .answer_in(ans),
    .dly_in(dly), .len_in(len), .go_in(go), .lfps_out(rx),
    .warm_det_out(wdet));
  task automatic chk(string n, logic e, logic g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wait_hs;
    for (int i = 0; i < 3000 && ok !== 1'b1 && ko !== 1'b1; i++)
      @(posedge clk) #1;
  endtask
  // controller starts an exit, partner answers d cycles after validating it
  task automatic t_init(logic [1:0] k, logic [15:0] d, logic r, logic e,
                        int mn, logic [1:0] rl);
    @(posedge clk);
    kd <= k;
    dly <= d;
    rdy <= r;
    ans <= 1'b1;
    u2t <= rl[0];
    imm <= rl[1];
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    #1 chk("tx on", 1'b1, tx);
    chk("busy on", 1'b1, bz);
    wait_hs();
    chk("success", e, ok);
    chk("failure", !e, ko);
    chk("ss start", e && k != `KIND_LPBK, ss);
    chk("tx held", 1'b1, txn >= mn);
    chk("busy off", 1'b0, bz);
    repeat (20) @(posedge clk);
  endtask
  // u1 exit with the clock enable low for ten cycles after the start
  task automatic t_freeze;
    @(posedge clk);
    kd <= `KIND_U1;
    dly <= 16'h0000;
    rdy <= 1'b1;
    ans <= 1'b1;
    u2t <= 1'b0;
    imm <= 1'b0;
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    en <= 1'b0;
    repeat (10) @(posedge clk);
    en <= 1'b1;
    #1 chk("tx frozen", 1'b1, tx);
    chk("busy frozen", 1'b1, bz);
    wait_hs();
    chk("frozen success", 1'b1, ok);
    chk("frozen held", 1'b1, txn >= 123);
    repeat (20) @(posedge clk);
  endtask
  // partner sends a burst of n cycles, controller may answer
  task automatic t_resp(logic [1:0] k, logic [15:0] n, logic e, int mn,
                        int mx);
    @(posedge clk);
    kd <= k;
    rdy <= 1'b1;
    ans <= 1'b0;
    arm <= 1'b1;
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk("answer", e, tx);
    if (e)
      wait_hs();
    chk("resp success", e, ok);
    chk("resp failure", 1'b0, ko);
    chk("resp ss start", e, ss);
    chk("resp held", 1'b1, !e || (txn >= mn && txn <= mx));
    @(posedge clk);
    arm <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  // warm reset refused while disabled, then one full burst
  task automatic t_warm;
    @(posedge clk);
    dis <= 1'b1;
    wreq <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("warm blocked", 1'b0, wa);
    @(posedge clk);
    dis <= 1'b0;
    @(posedge clk);
    wreq <= 1'b0;
    #1 chk("warm on", 1'b1, wa);
    repeat (C_WARM) @(posedge clk);
    #1 chk("warm done", 1'b1, wd);
    chk("warm length", 1'b1, txn == C_WARM);
    chk("partner held", 1'b1, wdet);
    @(posedge clk);
    #1 chk("partner freed", 1'b0, wdet);
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_init(`KIND_U1, 16'h0000, 1'b1, 1'b1, 113, 2'h0);
    t_init(`KIND_U2, 16'h0000, 1'b1, 1'b1, 200, 2'h0);
    t_init(`KIND_LPBK, 16'h0000, 1'b0, 1'b1, 200, 2'h0);
    t_init(`KIND_U3, 16'h02bc, 1'b1, 1'b1, 200, 2'h0);
    t_init(`KIND_U2, 16'h02bc, 1'b1, 1'b0, 600, 2'h0);
    t_init(`KIND_U1, 16'h0000, 1'b0, 1'b0, 250, 2'h0);
    t_init(`KIND_U1, 16'h0000, 1'b0, 1'b0, 600, 2'h1);
    t_init(`KIND_U1, 16'h0000, 1'b0, 1'b0, 600, 2'h2);
    t_freeze();
    t_resp(`KIND_U1, 16'h0014, 1'b0, 0, 0);
    t_resp(`KIND_U1, 16'h0080, 1'b1, 113, 150);
    t_resp(`KIND_U2, 16'h0080, 1'b1, 200, 600);
    t_warm();
    wrap_up();
  end
endmodule
bind lfps_exit_handshake_warm_reset lfps_hs_checker #(.C_WARM(C_WARM)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
  .start_exit_in(start_exit_in), .warm_reset_req_in(warm_reset_req_in),
  .link_disabled_in(link_disabled_in), .lfps_tx_out(lfps_tx_out),
  .ss_tx_start_out(ss_tx_start_out), .hs_success_out(hs_success_out),
  .hs_fail_out(hs_fail_out), .warm_active_out(warm_active_out),
  .warm_done_out(warm_done_out), .busy_out(busy_out));
`default_nettype wire

// ==== lfps_hs_checker_assertions.sv ====
// assertions watching the lfps handshake controller ports
`default_nettype none
module lfps_hs_checker #(
  parameter [23:0] C_WARM = 24'h0190 // warm burst cycles
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic start_exit_in,
  input wire logic warm_reset_req_in,
  input wire logic link_disabled_in,
  input wire logic lfps_tx_out,
  input wire logic ss_tx_start_out,
  input wire logic hs_success_out,
  input wire logic hs_fail_out,
  input wire logic warm_active_out,
  input wire logic warm_done_out,
  input wire logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] tx_reg;   // cycles of unbroken lfps sent
  logic [23:0] warm_reg; // cycles of warm burst so far
  // run counters, cleared while the burst is absent
  always @(posedge clk_sys_in)
  begin
    tx_reg   <= (!rst_b_in || !lfps_tx_out) ? 24'h0 : tx_reg + clk_en_in;
    warm_reg <= (!rst_b_in || !warm_active_out) ? 24'h0
                : warm_reg + clk_en_in;
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  a_tx_stands: assert property (
    $fell(lfps_tx_out) |-> hs_success_out || hs_fail_out || warm_done_out)
    else $error("lfps stopped without a verdict");
  a_ss_gap: assert property (
    ss_tx_start_out |-> hs_success_out && !lfps_tx_out && $past(lfps_tx_out))
    else $error("superspeed start not at lfps end");
  a_ok_pulse: assert property (
    hs_success_out && clk_en_in |=> !hs_success_out)
    else $error("success pulse too long");
  a_succ_min: assert property (
    hs_success_out |-> tx_reg >= 24'h0071)
    else $error("success before 900 ns of lfps");
  a_start_tx: assert property (
    !busy_out && clk_en_in && start_exit_in && !warm_reset_req_in
    |=> lfps_tx_out && busy_out) else $error("exit start not taken");
  a_warm_take: assert property (
    !busy_out && clk_en_in && warm_reset_req_in && !link_disabled_in
    |=> warm_active_out && lfps_tx_out) else $error("warm request lost");
  a_warm_block: assert property (
    !busy_out && warm_reset_req_in && link_disabled_in |=> !warm_active_out)
    else $error("warm reset while disabled");
  a_warm_len: assert property (
    warm_done_out |-> warm_reg == C_WARM && !lfps_tx_out)
    else $error("warm burst length wrong");
  cover property (hs_success_out);
  cover property (hs_fail_out);
  cover property (warm_done_out);
endmodule
`default_nettype wire

// ==== lfps_hs_regs.vh ====
// timing constants, encodings and widths for the lfps handshake controller
`ifndef LFPS_HS_REGS_VH
`define LFPS_HS_REGS_VH

// local clock rate
`define CLK_MHZ        125

// counter width, large enough for the warm reset burst
`define CNT_W          24

// handshake kinds
`define KIND_U1        2'h0
`define KIND_U2        2'h1
`define KIND_LPBK      2'h2
`define KIND_U3        2'h3

// times in their own units
`define T_VALID_NS     300
`define T_TAIL_NS      600
`define T_U1_TOT_NS    900
`define T_U1_RESP_NS   900
`define T_U1_RMAX_NS   1200
`define T_U1_SMAX_NS   2000
`define T_LONG_MIN_US  80
`define T_REL_MS       2
`define T_U3_MS        10
`define T_WARM_MS      100

// time to cycles, least times round up, longest times round down
`define NS2CYC_UP(t)   ((((t) * `CLK_MHZ) + 999) / 1000)
`define NS2CYC_DN(t)   (((t) * `CLK_MHZ) / 1000)
`define US2CYC(t)      ((t) * `CLK_MHZ)
`define MS2CYC(t)      ((t) * 1000 * `CLK_MHZ)

// one-hot state codes
`define ST_IDLE        5'h01
`define ST_INIT        5'h02
`define ST_RESP        5'h04
`define ST_WARM        5'h08
`define ST_SPARE       5'h10

// state bits read straight out as outputs
`define ST_IDLE_BIT    0
`define ST_WARM_BIT    3

`endif

// ==== lfps_usp_model.sv ====
// behavioural upstream port: answers exit lfps, detects warm reset
`default_nettype none
module lfps_usp_model #(
  parameter int VALID    = 38, // 300 ns at 125 MHz
  parameter int WARM_DET = 300 // shortened warm detect time
) (
  input  wire logic        clk_in,      // local clock
  input  wire logic        tx_in,       // lfps from the controller
  input  wire logic        answer_in,   // answer exit lfps
  input  wire logic [15:0] dly_in,      // extra answer delay
  input  wire logic [15:0] len_in,      // own burst length
  input  wire logic        go_in,       // start own burst
  output var  logic        lfps_out,    // lfps toward the controller
  output var  logic        warm_det_out // reset held by the port
);
  timeunit 1ns;
  timeprecision 1ps;
  int run  = 0; // cycles of received burst
  int hold = 0; // cycles since burst became valid
  int own  = 0; // cycles left of own burst
  // local clock counters time every burst
  always @(posedge clk_in)
  begin
    run  <= tx_in ? run + 1 : 0;
    hold <= (tx_in && run >= VALID) ? hold + 1 : 0;
    own  <= go_in ? len_in : (own > 0 ? own - 1 : 0);
    lfps_out <= go_in || own > 1 ||
                (answer_in && run >= VALID && hold >= dly_in);
    warm_det_out <= tx_in && (warm_det_out || run >= WARM_DET);
  end
endmodule
`default_nettype wire
